// *** core/mms_pkg.sv ***
package mms_pkg;

  // Register map
  localparam logic [5:0] MMS_ADDR_MEASUREMENT_MODE = 6'h0B;
  localparam logic [7:0] MMS_MEASUREMENT_MODE_RESET           = 8'h70;
  localparam int         MMS_PERIOD_LSB            = 0;
  localparam int         MMS_PEAK_LSB              = 2;
  localparam int         MMS_ZX_LSB                = 4;
  localparam int         MMS_SAMPLE_W              = 24;

  // Phase selection codes
  localparam logic [1:0] MMS_SEL_A        = 2'h0;
  localparam logic [1:0] MMS_SEL_B        = 2'h1;
  localparam logic [1:0] MMS_SEL_C        = 2'h2;
  localparam logic [1:0] MMS_SEL_RESERVED = 2'h3;

endpackage

// *** core/mms_phase_mux.sv ***
`timescale 1ns/10ps
module mms_phase_mux
  import mms_pkg::*;
(
  input  wire logic [1:0]              sel_i,
  input  wire logic [MMS_SAMPLE_W-1:0] phase_a_i,
  input  wire logic [MMS_SAMPLE_W-1:0] phase_b_i,
  input  wire logic [MMS_SAMPLE_W-1:0] phase_c_i,
  output logic      [MMS_SAMPLE_W-1:0] sel_o,
  output logic                         valid_o
);

  // Reserved code selects nothing, so downstream logic stays quiet
  always_comb begin
    sel_o   = '0;
    valid_o = 1'b1;
    unique case (sel_i)
      MMS_SEL_A: sel_o = phase_a_i;
      MMS_SEL_B: sel_o = phase_b_i;
      MMS_SEL_C: sel_o = phase_c_i;
      MMS_SEL_RESERVED: valid_o = 1'b0;
    endcase
  end

endmodule

// *** core/mms_measurement_mode.sv ***
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module mms_measurement_mode
  import mms_pkg::*;
(
  input  wire logic                    sys_clk_i,
  input  wire logic                    resetn_i,
  input  wire logic [5:0]              reg_addr_i,
  input  wire logic                    reg_wr_i,
  input  wire logic [7:0]              reg_wdata_i,
  output logic      [7:0]              reg_rdata_o,
  input  wire logic [2:0]              zero_cross_i,
  input  wire logic                    line_accum_mode_i,
  input  wire logic [MMS_SAMPLE_W-1:0] volt_a_i,
  input  wire logic [MMS_SAMPLE_W-1:0] volt_b_i,
  input  wire logic [MMS_SAMPLE_W-1:0] volt_c_i,
  input  wire logic [MMS_SAMPLE_W-1:0] curr_a_i,
  input  wire logic [MMS_SAMPLE_W-1:0] curr_b_i,
  input  wire logic [MMS_SAMPLE_W-1:0] curr_c_i,
  input  wire logic [MMS_SAMPLE_W-1:0] voltage_peak_threshold_i,
  input  wire logic [MMS_SAMPLE_W-1:0] current_peak_threshold_i,
  output logic      [1:0]              period_source_sel_o,
  output logic      [1:0]              peak_source_sel_o,
  output logic      [2:0]              zero_cross_phase_enable_o,
  output logic                         period_zero_cross_o,
  output logic      [2:0]              zero_cross_enabled_o,
  output logic                         accum_zero_cross_o,
  output logic                         voltage_peak_flag_o,
  output logic                         current_peak_flag_o
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [1:0] period_sel;
    logic [1:0] peak_sel;
    logic [2:0] zx_en;
    logic       period_zx;
    logic [2:0] zx_gated;
    logic       accum_zx;
    logic       vpeak;
    logic       ipeak;
  } mms_state_s;

  mms_state_s                 q;
  mms_state_s                 d;
  logic [MMS_SAMPLE_W-1:0]    peak_volt;
  logic [MMS_SAMPLE_W-1:0]    peak_curr;
  logic                       volt_ok;
  logic                       curr_ok;
  logic [1:0]                 per_idx;

  ////////////////////////////////////////////////////////////////////////////
  mms_phase_mux u_volt_mux (
    .sel_i     (q.peak_sel),
    .phase_a_i (volt_a_i),
    .phase_b_i (volt_b_i),
    .phase_c_i (volt_c_i),
    .sel_o     (peak_volt),
    .valid_o   (volt_ok)
  );

  mms_phase_mux u_curr_mux (
    .sel_i     (q.peak_sel),
    .phase_a_i (curr_a_i),
    .phase_b_i (curr_b_i),
    .phase_c_i (curr_c_i),
    .sel_o     (peak_curr),
    .valid_o   (curr_ok)
  );

  assign per_idx = q.period_sel;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    d = q;
    if (reg_wr_i && reg_addr_i == MMS_ADDR_MEASUREMENT_MODE) begin
      // Bit 7 has no storage, so writes to it vanish
      d.period_sel = reg_wdata_i[MMS_PERIOD_LSB +: 2];
      d.peak_sel   = reg_wdata_i[MMS_PEAK_LSB +: 2];
      d.zx_en      = reg_wdata_i[MMS_ZX_LSB +: 3];
    end
    d.zx_gated = zero_cross_i & q.zx_en;
    // Reserved period code gives no period events
    d.period_zx = (per_idx != MMS_SEL_RESERVED) && zero_cross_i[per_idx]
                  && q.zx_en[per_idx];
    d.accum_zx = line_accum_mode_i && |(zero_cross_i & q.zx_en);
    d.vpeak = volt_ok && (peak_volt > voltage_peak_threshold_i);
    d.ipeak = curr_ok && (peak_curr > current_peak_threshold_i);
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q            <= '0;
      q.period_sel <= MMS_MEASUREMENT_MODE_RESET[MMS_PERIOD_LSB +: 2];
      q.peak_sel   <= MMS_MEASUREMENT_MODE_RESET[MMS_PEAK_LSB +: 2];
      q.zx_en      <= MMS_MEASUREMENT_MODE_RESET[MMS_ZX_LSB +: 3];
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data is combinational on address; unmapped reads return zero
  always_comb begin
    reg_rdata_o = 8'h00;
    if (reg_addr_i == MMS_ADDR_MEASUREMENT_MODE) begin
      reg_rdata_o = {1'b0, q.zx_en, q.peak_sel, q.period_sel};
    end
  end

  assign period_source_sel_o       = q.period_sel;
  assign peak_source_sel_o         = q.peak_sel;
  assign zero_cross_phase_enable_o = q.zx_en;
  assign period_zero_cross_o       = q.period_zx;
  assign zero_cross_enabled_o      = q.zx_gated;
  assign accum_zero_cross_o        = q.accum_zx;
  // Level outputs; the status register outside makes them sticky
  assign voltage_peak_flag_o       = q.vpeak;
  assign current_peak_flag_o       = q.ipeak;

endmodule

// *** verif/mms_measurement_mode_monitor.sv ***
`timescale 1ns/10ps
module mms_measurement_mode_monitor
  import mms_pkg::*;
(
  input wire logic       sys_clk_i,
  input wire logic       resetn_i,
  input wire logic [5:0] reg_addr_i,
  input wire logic       reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [2:0] zero_cross_i,
  input wire logic       line_accum_mode_i,
  input wire logic [1:0] period_source_sel_o,
  input wire logic [1:0] peak_source_sel_o,
  input wire logic [2:0] zero_cross_phase_enable_o,
  input wire logic       period_zero_cross_o,
  input wire logic [2:0] zero_cross_enabled_o,
  input wire logic       accum_zero_cross_o
);
  logic [2:0] en;
  logic [6:0] f;
  assign en = zero_cross_i & zero_cross_phase_enable_o;
  assign f  = {zero_cross_phase_enable_o, peak_source_sel_o, period_source_sel_o};
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_wr; reg_wr_i && reg_addr_i == MMS_ADDR_MEASUREMENT_MODE; endsequence
  // Foreign writes share the strobe, so they must leave every field alone
  sequence s_foreign; reg_wr_i && reg_addr_i != MMS_ADDR_MEASUREMENT_MODE; endsequence
  chk_field_load: assert property (s_wr |=> f == $past(reg_wdata_i[6:0]))
    else $error("field load");
  chk_bad_addr: assert property (s_foreign |=> $stable(f))
    else $error("foreign write");
  chk_read_back: assert property (
    reg_addr_i == MMS_ADDR_MEASUREMENT_MODE |-> reg_rdata_o == {1'b0, f})
    else $error("readback");
  chk_zx_gate: assert property (1'b1 |=> zero_cross_enabled_o == $past(en))
    else $error("gate");
  chk_accum_on: assert property (line_accum_mode_i |=> accum_zero_cross_o == $past(|en))
    else $error("accum");
  chk_accum_off: assert property (!line_accum_mode_i |=> !accum_zero_cross_o)
    else $error("idle");
  chk_period_pick: assert property (period_source_sel_o != 2'h3 |=>
    period_zero_cross_o == $past(en[period_source_sel_o])) else $error("period");
  chk_period_rsvd: assert property (period_source_sel_o == 2'h3 |=> !period_zero_cross_o)
    else $error("reserved");
endmodule
bind mms_measurement_mode mms_measurement_mode_monitor u_mon (.*);

// *** verif/mms_measurement_mode_tb.sv ***
`timescale 1ns/10ps
module mms_measurement_mode_tb;
  import mms_pkg::*;
  logic sys_clk_i = 1'b0, resetn_i = 1'b0, reg_wr_i = 1'b0, line_accum_mode_i = 1'b0;
  logic [5:0] reg_addr_i = 6'h0B;
  logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o, m, e;
  logic [2:0] zero_cross_i = 3'h0, zero_cross_phase_enable_o, zero_cross_enabled_o, en;
  logic [1:0] period_source_sel_o, peak_source_sel_o;
  logic period_zero_cross_o, accum_zero_cross_o, voltage_peak_flag_o, current_peak_flag_o;
  logic [23:0] volt_a_i = 24'h0, volt_b_i = 24'h0, volt_c_i = 24'h0, curr_a_i = 24'h0;
  logic [23:0] curr_b_i = 24'h0, curr_c_i = 24'h0, voltage_peak_threshold_i = 24'h0;
  logic [23:0] current_peak_threshold_i = 24'h0;
  logic [7:0] corner [4] = '{8'hFF, 8'h00, 8'h26, 8'h59};
  int seed = 23, error_cnt = 0, checks = 0, r;
  always #4 sys_clk_i = ~sys_clk_i;
  mms_measurement_mode u_dut (.*);
  function automatic logic pk(input logic [1:0] s, input logic [23:0] x0, x1, x2, t);
    return (s == 2'h0 && x0 > t) || (s == 2'h1 && x1 > t) || (s == 2'h2 && x2 > t);
  endfunction
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    m = MMS_MEASUREMENT_MODE_RESET;
    repeat (3) @(negedge sys_clk_i);
    cmp(reg_rdata_o, MMS_MEASUREMENT_MODE_RESET);
    resetn_i = 1'b1;
    for (int i = 0; i < 400; i++) begin
      r = $random(seed);
      reg_wr_i = r[0] | (i < 4);
      reg_addr_i = (i < 4) ? 6'h0B : {5'h05, r[1]};
      reg_wdata_i = (i < 4) ? corner[i] : r[15:8];
      zero_cross_i = r[4:2];
      line_accum_mode_i = r[5];
      // Two-bit samples so ties with thresholds are frequent
      {volt_a_i[1:0], volt_b_i[1:0], volt_c_i[1:0], curr_a_i[1:0], curr_b_i[1:0],
       curr_c_i[1:0], voltage_peak_threshold_i[1:0], current_peak_threshold_i[1:0]} = r[31:16];
      en = zero_cross_i & m[6:4];
      e = {1'b0, line_accum_mode_i & |en, m[1:0] != 2'h3 && en[m[1:0]],
           pk(m[3:2], volt_a_i, volt_b_i, volt_c_i, voltage_peak_threshold_i),
           pk(m[3:2], curr_a_i, curr_b_i, curr_c_i, current_peak_threshold_i), en};
      if (reg_wr_i && reg_addr_i == MMS_ADDR_MEASUREMENT_MODE) m = reg_wdata_i & 8'h7F;
      @(negedge sys_clk_i);
      cmp({1'b0, accum_zero_cross_o, period_zero_cross_o, voltage_peak_flag_o,
           current_peak_flag_o, zero_cross_enabled_o}, e);
      cmp(reg_rdata_o, (reg_addr_i == MMS_ADDR_MEASUREMENT_MODE) ? m : 8'h00);
      cmp({1'b0, zero_cross_phase_enable_o, peak_source_sel_o, period_source_sel_o}, m);
    end
    end_sim;
  end
endmodule
